// file: pkg/supervisor_pkg.sv
`default_nettype none
package supervisor_pkg;
  // clock rate and timebase figures
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned OSC_HZ = 10240;
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  // watchdog and reset periods in milliseconds, and the timebase ticks they give
  localparam int unsigned WD_SHORT_MS = 100;
  localparam int unsigned WD_LONG_MS = 1600;
  localparam int unsigned RST_MS = 50;
  localparam int unsigned INT_SHORT_TICKS = OSC_HZ * WD_SHORT_MS / 1000;
  localparam int unsigned INT_LONG_TICKS = OSC_HZ * WD_LONG_MS / 1000;
  localparam int unsigned INT_RST_TICKS = OSC_HZ * RST_MS / 1000;
  localparam int unsigned EXT_SHORT_TICKS = 1024;
  localparam int unsigned EXT_LONG_TICKS = 4096;
  localparam int unsigned EXT_RST_TICKS = 512;
  // must hold the long period of 16384 ticks itself, not only the count below it
  localparam int unsigned TICK_W = 15;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LONG = 2'b01,
    ST_SHORT = 2'b10
  } wd_state_t;
endpackage
`default_nettype wire

// file: src/timebase_tick.sv
`timescale 1ns/1ps
`default_nettype none
module timebase_tick #(
  parameter int unsigned DIV = supervisor_pkg::OSC_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic hold,
  input wire logic useInternal,
  input wire logic extClk,
  // tick out
  output logic tick
);
  import supervisor_pkg::*;

  logic [31:0] div_ff, nxt_div;
  logic extPrev_ff, nxt_extPrev;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_div = div_ff;
    nxt_extPrev = extPrev_ff;
    nxt_tick = 1'b0;
    // inputs are frozen during backup so pin levels change nothing
    if (!hold) begin
      nxt_extPrev = extClk;
      if (useInternal) begin
        if (div_ff >= DIV - 1) begin
          nxt_div = 32'h0;
          nxt_tick = 1'b1;
        end else begin
          nxt_div = div_ff + 32'h1;
        end
      end else begin
        nxt_div = 32'h0;
        nxt_tick = extClk & ~extPrev_ff;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_ff <= 32'h0;
      extPrev_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      extPrev_ff <= nxt_extPrev;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule
`default_nettype wire

// file: src/supervisor_backup_output_gating.sv
// Overview of operation
// - normal mode: power-fail flag low when sense input below reference, else high
// - backup: active-low reset low, active-high reset high, low-line flag low
// - backup: power-fail comparator ignored and power-fail flag forced low
// - backup: kick, source select and timebase pin change no state
// - backup: backup-active output driven high
// - backup: watchdog-expired output forced high
// - backup: chip enable input ignored, gated chip enable held high
// - floating kick input disables the watchdog entirely
// - source select low: timebase ticks come from the timebase pin
// - source select high: internal oscillator drives the timebase
// - internal oscillator gives 100 ms or 1.6 s watchdog timeout
// - timebase pin low picks 100 ms after a kick, high or floating picks 1.6 s; the first period after reset is always 1.6 s
// - reset held a further 50 ms after line sense recovers
// - every kick edge restarts the watchdog count from zero
// - timeout drives expired flag low until next kick edge, low line sense or backup
`timescale 1ns/1ps
`default_nettype none
module supervisor_backup_output_gating #(
  parameter int unsigned TICK_DIV = supervisor_pkg::OSC_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // supply monitoring
  input wire logic backupMode,
  input wire logic lineSenseOk,
  input wire logic powerFailSenseLow,
  // watchdog pins
  input wire logic watchdogKickIn,
  input wire logic watchdogKickFloat,
  input wire logic timebaseSourceSel,
  input wire logic timebasePin,
  // chip enable gating
  input wire logic chipEnableIn_n,
  output logic chipEnableGated_n,
  // status outputs
  output logic reset_n,
  output logic resetOut,
  output logic lowLineFlag_n,
  output logic powerFailFlag_n,
  output logic backupActiveOut,
  output logic watchdogExpired_n
);
  import supervisor_pkg::*;

  logic tick;
  logic [TICK_W-1:0] cnt_ff, nxt_cnt;
  wd_state_t state_ff, nxt_state;
  logic kickPrev_ff, nxt_kickPrev;
  logic expired_ff, nxt_expired;
  logic pfFlag_ff, nxt_pfFlag;
  logic lowLine_ff, nxt_lowLine;
  logic strapShort_ff, nxt_strapShort;
  logic useInternal;
  logic kickEdge;
  logic [TICK_W-1:0] rstTicks, shortTicks, longTicks;

  assign useInternal = timebaseSourceSel;

  timebase_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .hold(backupMode),
    .useInternal(useInternal),
    .extClk(timebasePin),
    .tick(tick)
  );

  // timebase pin only picks the period on the internal oscillator
  assign rstTicks = useInternal ? TICK_W'(INT_RST_TICKS) : TICK_W'(EXT_RST_TICKS);
  assign longTicks = useInternal ? TICK_W'(INT_LONG_TICKS) : TICK_W'(EXT_LONG_TICKS);
  assign shortTicks = !useInternal ? TICK_W'(EXT_SHORT_TICKS) :
                      strapShort_ff ? TICK_W'(INT_SHORT_TICKS) : TICK_W'(INT_LONG_TICKS);

  // a floating kick pin never counts as an edge
  assign kickEdge = !watchdogKickFloat && (watchdogKickIn != kickPrev_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_kickPrev = kickPrev_ff;
    nxt_expired = expired_ff;
    nxt_strapShort = strapShort_ff;
    if (backupMode) begin
      // park in reset so release gives a full power-on reset period
      nxt_state = ST_RESET;
      nxt_cnt = '0;
      nxt_expired = 1'b0;
    end else if (!lineSenseOk) begin
      nxt_state = ST_RESET;
      nxt_cnt = '0;
      nxt_expired = 1'b0;
    end else begin
      nxt_kickPrev = watchdogKickIn;
      nxt_strapShort = ~timebasePin;
      if (kickEdge) begin
        nxt_expired = 1'b0;
      end
      unique case (state_ff)
        ST_RESET: begin
          if (tick) begin
            if (cnt_ff >= rstTicks - TICK_W'(1)) begin
              nxt_state = ST_LONG;
              nxt_cnt = '0;
            end else begin
              nxt_cnt = cnt_ff + TICK_W'(1);
            end
          end
        end
        ST_LONG, ST_SHORT: begin
          if (watchdogKickFloat) begin
            nxt_cnt = '0;
          end else if (kickEdge) begin
            nxt_cnt = '0;
            nxt_state = ST_SHORT;
          end else if (tick) begin
            if (cnt_ff >= (state_ff == ST_LONG ? longTicks : shortTicks) - TICK_W'(1)) begin
              nxt_expired = 1'b1;
              nxt_state = ST_RESET;
              nxt_cnt = '0;
            end else begin
              nxt_cnt = cnt_ff + TICK_W'(1);
            end
          end
        end
        default: begin
          nxt_state = ST_RESET;
          nxt_cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_RESET;
      cnt_ff <= '0;
      kickPrev_ff <= 1'b0;
      expired_ff <= 1'b0;
      strapShort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      kickPrev_ff <= nxt_kickPrev;
      expired_ff <= nxt_expired;
      strapShort_ff <= nxt_strapShort;
    end
  end

  always_comb begin
    nxt_pfFlag = ~powerFailSenseLow;
    nxt_lowLine = lineSenseOk;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pfFlag_ff <= 1'b0;
      lowLine_ff <= 1'b0;
    end else begin
      pfFlag_ff <= nxt_pfFlag;
      lowLine_ff <= nxt_lowLine;
    end
  end

  // backup forcing is combinational from one indicator for zero added latency
  assign reset_n = backupMode ? 1'b0 : (state_ff != ST_RESET);
  assign resetOut = backupMode ? 1'b1 : (state_ff == ST_RESET);
  assign lowLineFlag_n = backupMode ? 1'b0 : lowLine_ff;
  assign powerFailFlag_n = backupMode ? 1'b0 : pfFlag_ff;
  assign backupActiveOut = backupMode;
  assign watchdogExpired_n = backupMode ? 1'b1 : ~expired_ff;
  assign chipEnableGated_n = (backupMode || !lineSenseOk) ? 1'b1 : chipEnableIn_n;

  chk_backup_outputs: assert property (@(posedge clk) disable iff (reset)
    backupMode |-> (!reset_n && resetOut && !lowLineFlag_n))
    else $error("backup reset outputs wrong");
  chk_backup_fail_flag: assert property (@(posedge clk) disable iff (reset)
    backupMode |-> !powerFailFlag_n)
    else $error("power fail flag not forced low");
  chk_fail_follow: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && !backupMode && !$past(backupMode)) |-> (powerFailFlag_n == !$past(powerFailSenseLow)))
    else $error("power fail flag does not follow sense");
  chk_backup_hold: assert property (@(posedge clk) disable iff (reset)
    $past(backupMode) |-> (kickPrev_ff == $past(kickPrev_ff) && strapShort_ff == $past(strapShort_ff)))
    else $error("pins changed state in backup");
  chk_backup_flag: assert property (@(posedge clk) disable iff (reset)
    backupActiveOut == backupMode)
    else $error("backup active wrong");
  chk_expired_backup: assert property (@(posedge clk) disable iff (reset)
    backupMode |-> watchdogExpired_n)
    else $error("expired flag not high in backup");
  chk_ce_block: assert property (@(posedge clk) disable iff (reset)
    backupMode |-> chipEnableGated_n)
    else $error("chip enable not blocked");
  chk_float_quiet: assert property (@(posedge clk) disable iff (reset)
    (watchdogKickFloat && !backupMode && lineSenseOk && state_ff != ST_RESET) |=> (cnt_ff == '0 && state_ff != ST_RESET))
    else $error("floating kick still times out");
  chk_kick_restart: assert property (@(posedge clk) disable iff (reset)
    (kickEdge && !backupMode && lineSenseOk && state_ff != ST_RESET) |=> (cnt_ff == '0 && state_ff == ST_SHORT))
    else $error("kick edge did not restart count");
  chk_exit_reset: assert property (@(posedge clk) disable iff (reset)
    ($past(backupMode) && !backupMode) |-> (state_ff == ST_RESET && cnt_ff == '0 && !reset_n))
    else $error("backup exit not in reset");

  // helper counters for the timed checks; they count timebase ticks on their own,
  // so a wrong limit or a missed clear in the watchdog counter still shows up
  logic [TICK_W-1:0] rstSeen_ff, nxt_rstSeen;
  logic [TICK_W-1:0] wdSeen_ff, nxt_wdSeen;

  always_comb begin
    nxt_rstSeen = '0;
    nxt_wdSeen = '0;
    if (!backupMode && lineSenseOk) begin
      if (!reset_n) begin
        nxt_rstSeen = tick ? rstSeen_ff + TICK_W'(1) : rstSeen_ff;
      end else if (!watchdogKickFloat && !kickEdge) begin
        nxt_wdSeen = tick ? wdSeen_ff + TICK_W'(1) : wdSeen_ff;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rstSeen_ff <= '0;
      wdSeen_ff <= '0;
    end else begin
      rstSeen_ff <= nxt_rstSeen;
      wdSeen_ff <= nxt_wdSeen;
    end
  end

  // steps of the watchdog status behaviour
  sequence seq_expired_low;
    !watchdogExpired_n && !backupMode && lineSenseOk;
  endsequence
  sequence seq_no_kick;
    !kickEdge;
  endsequence
  sequence seq_floating;
    watchdogKickFloat && !backupMode && lineSenseOk && reset_n;
  endsequence

  chk_expired_hold: assert property (@(posedge clk) disable iff (reset)
    seq_expired_low ##0 seq_no_kick |=> (backupMode || !watchdogExpired_n))
    else $error("expired flag released without a kick");
  chk_kick_clears: assert property (@(posedge clk) disable iff (reset)
    (kickEdge && !backupMode && lineSenseOk) |=> (backupMode || watchdogExpired_n))
    else $error("kick edge did not release expired flag");
  chk_expiry_reset: assert property (@(posedge clk) disable iff (reset)
    $fell(watchdogExpired_n) |-> (!reset_n && resetOut))
    else $error("expiry without reset");
  chk_expiry_span: assert property (@(posedge clk) disable iff (reset)
    $fell(watchdogExpired_n) |-> (wdSeen_ff >= TICK_W'(EXT_SHORT_TICKS)))
    else $error("watchdog expired too early");
  chk_float_no_expiry: assert property (@(posedge clk) disable iff (reset)
    seq_floating |=> !$fell(watchdogExpired_n))
    else $error("floating kick pin caused expiry");
  chk_expired_line: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && !backupMode && !$past(lineSenseOk)) |-> watchdogExpired_n)
    else $error("expired flag low while line is low");

  // reset length is judged in ticks, so the check holds for any divider
  chk_reset_span: assert property (@(posedge clk) disable iff (reset)
    $rose(reset_n) |-> (rstSeen_ff >= rstTicks))
    else $error("reset released too early");
  chk_low_line: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && !backupMode && !$past(lineSenseOk)) |-> (!lowLineFlag_n && !reset_n))
    else $error("low line not reported");
  chk_reset_pair: assert property (@(posedge clk) disable iff (reset)
    resetOut == !reset_n)
    else $error("reset outputs not complementary");
  chk_state_legal: assert property (@(posedge clk) disable iff (reset)
    state_ff inside {ST_RESET, ST_LONG, ST_SHORT})
    else $error("watchdog state illegal");

  // timebase selection; backup holds the tick low, and the counters are held at zero by the backup branches
  chk_ext_tick: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && !$past(reset, 2) && !$past(backupMode) && !$past(backupMode, 2) && !$past(timebaseSourceSel))
      |-> (tick == ($past(timebasePin) && !$past(timebasePin, 2))))
    else $error("external tick does not follow pin edge");
  chk_backup_tick: assert property (@(posedge clk) disable iff (reset)
    $past(backupMode) |-> !tick)
    else $error("timebase ticked in backup");
  chk_strap_pick: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && !$past(backupMode) && $past(lineSenseOk)) |-> (strapShort_ff == !$past(timebasePin)))
    else $error("period strap not taken from pin");

  // a divider of one ticks every cycle and leaves no gap to check
  if (TICK_DIV > 1) begin : g_int_gap
    chk_int_gap: assert property (@(posedge clk) disable iff (reset)
      (tick && timebaseSourceSel && !backupMode) |=> !tick)
      else $error("internal timebase ticks back to back");
  end

  // chip enable passes straight through only while the line is good
  chk_ce_pass: assert property (@(posedge clk) disable iff (reset)
    (!backupMode && lineSenseOk) |-> (chipEnableGated_n == chipEnableIn_n))
    else $error("chip enable not passed through");
  chk_ce_line: assert property (@(posedge clk) disable iff (reset)
    !lineSenseOk |-> chipEnableGated_n)
    else $error("chip enable not blocked on low line");
endmodule
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk,
  // commands from the bench
  input wire logic kickNow,
  input wire logic letFloat,
  // kick pin
  output logic watchdogKickIn,
  output logic watchdogKickFloat
);
  initial begin
    watchdogKickIn = 1'b0;
    watchdogKickFloat = 1'b0;
  end
  // a released pin has no stable level, so it flips every cycle
  always @(negedge clk) begin
    watchdogKickFloat <= letFloat;
    if (letFloat || kickNow) begin
      watchdogKickIn <= ~watchdogKickIn;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import supervisor_pkg::*;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic bk = 1'b0, lineOk = 1'b1, pfLow = 1'b0, sel = 1'b1, pin = 1'b0, ceIn = 1'b1;
  logic kickNow = 1'b0, letFloat = 1'b0, extRun = 1'b0;
  wire logic kick, kickFl, ceOut, rstN, rstHi, llN, pffN, bkOut, expN;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 54;
  int took;
  always #2.5 clk = ~clk;
  // external timebase: a rising edge every four clocks, changed at a falling edge
  always #10 begin
    if (extRun) begin
      pin = ~pin;
    end
  end
  host_model host (.clk(clk), .kickNow(kickNow), .letFloat(letFloat), .watchdogKickIn(kick),
    .watchdogKickFloat(kickFl));
  supervisor_backup_output_gating #(.TICK_DIV(DIV)) dut (.clk(clk), .reset(reset), .backupMode(bk),
    .lineSenseOk(lineOk), .powerFailSenseLow(pfLow), .watchdogKickIn(kick), .watchdogKickFloat(kickFl),
    .timebaseSourceSel(sel), .timebasePin(pin), .chipEnableIn_n(ceIn), .chipEnableGated_n(ceOut),
    .reset_n(rstN), .resetOut(rstHi), .lowLineFlag_n(llN), .powerFailFlag_n(pffN),
    .backupActiveOut(bkOut), .watchdogExpired_n(expN));
  function automatic logic exp_fail_flag(input logic b, input logic low);
    return b ? 1'b0 : ~low;
  endfunction
  function automatic logic exp_ce(input logic b, input logic ok, input logic ce);
    return (b || !ok) ? 1'b1 : ce;
  endfunction
  // registered tick and tick phase make the exact count a few cycles loose
  function automatic logic near(input int got, input int want);
    return (got >= want - 4) && (got <= want + 16);
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wait_lvl(input logic onExp, input logic lvl, input int lim);
    for (took = 0; took < lim; took++) begin
      @(negedge clk);
      if ((onExp ? expN : rstN) === lvl) begin
        return;
      end
    end
    num_errors++;
    $display("wrong value wait level expected %b seen timeout", lvl);
    complete_run();
  endtask
  task automatic kick_once();
    kickNow <= 1'b1;
    @(negedge clk);
    kickNow <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset <= 1'b0;
    wait_lvl(1'b0, 1'b1, 4000);
    check("reset period", 1'b1, near(took, INT_RST_TICKS * DIV));
    check("reset high idle", 1'b0, rstHi);
    repeat (200) begin
      pfLow <= 1'($random(seed));
      ceIn <= 1'($random(seed));
      @(negedge clk);
      check("power fail flag", exp_fail_flag(bk, pfLow), pffN);
      check("chip enable", exp_ce(bk, lineOk, ceIn), ceOut);
      check("low line idle", 1'b1, llN);
    end
    lineOk <= 1'b0;
    repeat (2) @(negedge clk);
    check("reset low line", 1'b0, rstN);
    check("reset high line", 1'b1, rstHi);
    check("low line flag", 1'b0, llN);
    lineOk <= 1'b1;
    wait_lvl(1'b0, 1'b1, 4000);
    check("reset after line", 1'b1, near(took, INT_RST_TICKS * DIV));
    $display("test reset and sense done");
    kick_once();
    wait_lvl(1'b1, 1'b0, 6000);
    check("short timeout", 1'b1, near(took, INT_SHORT_TICKS * DIV));
    check("watchdog reset", 1'b0, rstN);
    kick_once();
    wait_lvl(1'b1, 1'b1, 8);
    check("expired release", 1'b1, expN);
    wait_lvl(1'b0, 1'b1, 4000);
    kick_once();
    letFloat <= 1'b1;
    repeat (6000) @(negedge clk);
    check("float expiry", 1'b1, expN);
    check("float reset", 1'b1, rstN);
    letFloat <= 1'b0;
    $display("test watchdog done");
    repeat (50) begin
      bk <= 1'b1;
      {pfLow, ceIn, sel, pin, kickNow} <= 5'($random(seed));
      @(negedge clk);
      check("reset low", 1'b0, rstN);
      check("reset high", 1'b1, rstHi);
      check("low line", 1'b0, llN);
      check("backup power flag", exp_fail_flag(bk, pfLow), pffN);
      check("backup active", 1'b1, bkOut);
      check("backup expired", 1'b1, expN);
      check("backup ce", exp_ce(bk, lineOk, ceIn), ceOut);
    end
    bk <= 1'b0;
    sel <= 1'b1;
    pin <= 1'b0;
    kickNow <= 1'b0;
    wait_lvl(1'b0, 1'b1, 4000);
    check("backup exit", 1'b1, near(took, INT_RST_TICKS * DIV));
    check("backup ignored", 1'b1, expN);
    $display("test backup done");
    sel <= 1'b0;
    extRun <= 1'b1;
    kick_once();
    wait_lvl(1'b1, 1'b0, 6000);
    check("external timeout", 1'b1, near(took, EXT_SHORT_TICKS * 4));
    $display("test external timebase done");
    complete_run();
  end
endmodule
`default_nettype wire
